// File: hdl/sad_decoder.sv
`default_nettype none
module sad_decoder
    import sad_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Processor request.
    input wire logic cpu_req,
    input wire logic cpu_wr,
    input wire logic [31:0] cpu_addr,
    input wire logic [3:0] cpu_size,
    input wire logic [7:0] cpu_wdata,
    // Map control pins.
    input wire logic alt_map_pin,
    input wire logic discontig_pin,
    // Inbound PCI request.
    input wire logic pci_in_req,
    input wire logic pci_in_io,
    input wire logic [31:0] pci_in_addr,
    // Board status inputs.
    input wire logic [7:0] kind_in,
    input wire logic [7:0] build_in,
    input wire logic [7:0] module_in,
    input wire logic [7:0] clock_ram_rdata,
    input wire logic [7:0] iack_vector,
    // Processor-side decode result.
    output logic dec_valid_r,
    output sad_pkg::sad_target_e dec_target_r,
    output logic [31:0] pci_addr_r,
    output logic pci_cfg_r,
    output logic [7:0] idsel_r,
    output logic [7:0] rdata_r,
    output logic alt_map_r,
    // Board register outputs.
    output logic [7:0] index_low_r,
    output logic [7:0] index_high_r,
    output logic [7:0] power_down_r,
    output logic clock_ram_wr_r,
    output logic clock_ram_rd_r,
    output logic [7:0] clock_ram_wdata_r,
    // Inbound decode result.
    output logic dram_in_valid_r,
    output logic [31:0] dram_in_addr_r,
    output logic pci_in_drop_r
);
    import sad_pkg::*;

    // ****************************************************************
    // Pin synchronisers.
    // ****************************************************************
    logic [1:0] alt_s1_r, alt_s2_r;
    logic alt_sw_r;
    logic [31:0] cfg_addr_reg_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            alt_s1_r <= 2'b00;
            alt_s2_r <= 2'b00;
        end else begin
            alt_s1_r <= {discontig_pin, alt_map_pin};
            alt_s2_r <= alt_s1_r;
        end
    end

    function automatic logic in_rng(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction

    // ****************************************************************
    // Decode.
    // ****************************************************************
    logic [31:0] off;
    logic [15:0] isa_a;
    logic discontig;
    logic is_isa;
    logic isa_exact;
    logic board_acc;
    logic is_cfg_data;
    sad_target_e tgt;
    logic [31:0] paddr;
    logic [7:0] idsel;

    assign off = cpu_addr - SAD_IO_BASE;
    assign discontig = alt_s2_r[1] || alt_sw_r;
    assign is_isa = in_rng(cpu_addr, SAD_IO_BASE, SAD_ISA_END);

    always_comb begin
        if (discontig) begin
            isa_a = {off[22:12], off[4:0]};
        end else begin
            isa_a = off[15:0];
        end
    end

    // Contiguous aliases above ISA 0xFFFF must not reach the onboard ports.
    assign isa_exact = is_isa && (discontig || off[22:16] == 7'h00);
    assign board_acc = cpu_req && isa_exact && (cpu_size == 4'h1);
    assign is_cfg_data = isa_exact && (isa_a[15:2] == SAD_CFG_DATA_PORT[15:2]);

    always_comb begin
        tgt = SAD_T_NONE;
        paddr = 32'h0000_0000;
        idsel = 8'h00;
        if (in_rng(cpu_addr, 32'h0000_0000, SAD_DRAM_END)) begin
            tgt = SAD_T_DRAM;
            paddr = cpu_addr;
        end else if (in_rng(cpu_addr, SAD_CFG_BASE, SAD_CFG_END)) begin
            tgt = SAD_T_PCI_CFG;
            paddr = off;
            idsel = off[SAD_IDSEL_HI:SAD_IDSEL_LO];
        end else if (is_isa) begin
            tgt = SAD_T_PCI_IO;
            paddr = discontig ? {16'h0000, isa_a} : off;
            if (is_cfg_data) begin
                tgt = SAD_T_PCI_CFG;
                paddr = {cfg_addr_reg_r[31:2], isa_a[1:0]};
                idsel = cfg_addr_reg_r[SAD_IDSEL_HI:SAD_IDSEL_LO];
            end
        end else if (in_rng(cpu_addr, SAD_IO_BASE, SAD_IO_END)) begin
            tgt = SAD_T_PCI_IO;
            paddr = off;
        end else if (in_rng(cpu_addr, SAD_RSV_BASE, SAD_RSV_END)) begin
            tgt = SAD_T_PCI_RSV;
            paddr = off;
        end else if (in_rng(cpu_addr, SAD_IACK_BASE, SAD_IACK_END)) begin
            tgt = cpu_wr ? SAD_T_PCI_RSV : SAD_T_PCI_IACK;
            paddr = off;
        end else if (in_rng(cpu_addr, SAD_MEM_BASE, SAD_MEM_END)) begin
            tgt = SAD_T_PCI_MEM;
            paddr = cpu_addr - SAD_MEM_BASE;
        end else begin
            tgt = cpu_addr[SAD_FLASH_BANK_BIT] ? SAD_T_FLASH1 : SAD_T_FLASH0;
            paddr = {12'h000, cpu_addr[19:0]};
        end
    end

    // ****************************************************************
    // Indirect configuration address and software map switch.
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_addr_reg_r <= 32'h0000_0000;
            alt_sw_r <= 1'b0;
        end else if (cpu_req && cpu_wr && isa_exact && isa_a[15:2] == SAD_CFG_ADDR_PORT[15:2]) begin
            cfg_addr_reg_r <= {24'h0000_00, cpu_wdata} << (8 * isa_a[1:0]);
        end else if (board_acc && cpu_wr && isa_a == SAD_POWER_DOWN_CONTROL) begin
            alt_sw_r <= cpu_wdata[7];
        end
    end

    // ****************************************************************
    // Board registers.
    // ****************************************************************
    logic breg_hit_r;
    logic [7:0] breg_rdata_r;

    sad_board_regs u_regs (
        .clk(clk),
        .rst_n(rst_n),
        .acc(board_acc),
        .wr(cpu_wr),
        .isa_addr(isa_a),
        .wdata(cpu_wdata),
        .kind_in(kind_in),
        .build_in(build_in),
        .module_in(module_in),
        .clock_ram_rdata(clock_ram_rdata),
        .hit_r(breg_hit_r),
        .rdata_r(breg_rdata_r),
        .index_low_r(index_low_r),
        .index_high_r(index_high_r),
        .power_down_r(power_down_r),
        .clock_ram_wr_r(clock_ram_wr_r),
        .clock_ram_rd_r(clock_ram_rd_r),
        .clock_ram_wdata_r(clock_ram_wdata_r)
    );

    logic pend_board_r;
    logic pend_iack_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dec_valid_r <= 1'b0;
            dec_target_r <= SAD_T_NONE;
            pci_addr_r <= 32'h0000_0000;
            pci_cfg_r <= 1'b0;
            idsel_r <= 8'h00;
            pend_board_r <= 1'b0;
            pend_iack_r <= 1'b0;
            alt_map_r <= 1'b0;
        end else begin
            dec_valid_r <= cpu_req;
            dec_target_r <= cpu_req ? tgt : SAD_T_NONE;
            pci_addr_r <= cpu_req ? paddr : 32'h0000_0000;
            pci_cfg_r <= cpu_req && (tgt == SAD_T_PCI_CFG);
            idsel_r <= (cpu_req && tgt == SAD_T_PCI_CFG) ? idsel : 8'h00;
            pend_board_r <= board_acc && !cpu_wr;
            pend_iack_r <= cpu_req && tgt == SAD_T_PCI_IACK;
            alt_map_r <= discontig;
        end
    end

    // ****************************************************************
    // Read data: board register or interrupt vector.
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_r <= 8'h00;
        end else if (pend_board_r && breg_hit_r) begin
            rdata_r <= breg_rdata_r;
        end else if (pend_iack_r) begin
            rdata_r <= iack_vector;
        end
    end

    // ****************************************************************
    // Inbound PCI decode.
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dram_in_valid_r <= 1'b0;
            dram_in_addr_r <= 32'h0000_0000;
            pci_in_drop_r <= 1'b0;
        end else begin
            dram_in_valid_r <= pci_in_req && !pci_in_io && pci_in_addr[31];
            dram_in_addr_r <= pci_in_addr - SAD_PCI_DRAM_BASE;
            pci_in_drop_r <= pci_in_req && (pci_in_io || !pci_in_addr[31]);
        end
    end

    // ****************************************************************
    // Checks.
    // ****************************************************************
    dram_local_a: assert property (@(posedge clk) disable iff (!rst_n)
        cpu_req && !cpu_addr[31] |=> dec_target_r == SAD_T_DRAM && !pci_cfg_r)
        else $error("low address not sent to DRAM");
    io_offset_a: assert property (@(posedge clk) disable iff (!rst_n)
        cpu_req && cpu_addr >= 32'h8100_0000 && cpu_addr <= 32'hBF7F_FFFF
        |=> pci_addr_r == $past(cpu_addr) - 32'h8000_0000)
        else $error("I/O offset wrong");
    cfg_window_a: assert property (@(posedge clk) disable iff (!rst_n)
        cpu_req && cpu_addr[31:23] == 9'h101 |=> pci_cfg_r && pci_addr_r[23] == 1'b1)
        else $error("configuration cycle not produced");
    rsv_forward_a: assert property (@(posedge clk) disable iff (!rst_n)
        cpu_req && cpu_addr >= 32'hBF80_0000 && cpu_addr <= 32'hBFFF_FFEF |=> dec_target_r == SAD_T_PCI_RSV)
        else $error("reserved window not forwarded");
    iack_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        cpu_req && !cpu_wr && cpu_addr[31:4] == 28'hBFF_FFFF |=> dec_target_r == SAD_T_PCI_IACK
        ##1 rdata_r == $past(iack_vector))
        else $error("interrupt acknowledge not run");
    mem_offset_a: assert property (@(posedge clk) disable iff (!rst_n)
        cpu_req && cpu_addr[31:30] == 2'b11 && cpu_addr[31:24] != 8'hFF
        |=> dec_target_r == SAD_T_PCI_MEM && pci_addr_r[31:30] == 2'b00)
        else $error("memory window offset wrong");
    flash_bank_a: assert property (@(posedge clk) disable iff (!rst_n)
        cpu_req && cpu_addr[31:24] == 8'hFF
        |=> dec_target_r == ($past(cpu_addr[19]) ? SAD_T_FLASH1 : SAD_T_FLASH0))
        else $error("flash bank wrong");
    idsel_map_a: assert property (@(posedge clk) disable iff (!rst_n)
        cpu_req && cpu_addr[31:23] == 9'h101 |=> idsel_r == $past(cpu_addr[18:11]))
        else $error("device select wrong");
    inbound_a: assert property (@(posedge clk) disable iff (!rst_n)
        pci_in_req |=> dram_in_valid_r != pci_in_drop_r)
        else $error("inbound cycle both kept and dropped");
    cov_dram_c: cover property (@(posedge clk) cpu_req && tgt == SAD_T_DRAM);
    cov_iack_c: cover property (@(posedge clk) pend_iack_r);
    cov_board_c: cover property (@(posedge clk) pend_board_r && breg_hit_r);
    cov_inbound_c: cover property (@(posedge clk) dram_in_valid_r);
endmodule // sad_decoder
`default_nettype wire

// File: hdl/sad_pkg.sv
`default_nettype none
package sad_pkg;
    // ****************************************************************
    // Processor-side region limits.
    // ****************************************************************
    localparam logic [31:0] SAD_DRAM_END = 32'h7FFF_FFFF;
    localparam logic [31:0] SAD_IO_BASE = 32'h8000_0000;
    localparam logic [31:0] SAD_ISA_END = 32'h807F_FFFF;
    localparam logic [31:0] SAD_CFG_BASE = 32'h8080_0000;
    localparam logic [31:0] SAD_CFG_END = 32'h80FF_FFFF;
    localparam logic [31:0] SAD_IO_END = 32'hBF7F_FFFF;
    localparam logic [31:0] SAD_RSV_BASE = 32'hBF80_0000;
    localparam logic [31:0] SAD_RSV_END = 32'hBFFF_FFEF;
    localparam logic [31:0] SAD_IACK_BASE = 32'hBFFF_FFF0;
    localparam logic [31:0] SAD_IACK_END = 32'hBFFF_FFFF;
    localparam logic [31:0] SAD_MEM_BASE = 32'hC000_0000;
    localparam logic [31:0] SAD_MEM_END = 32'hFEFF_FFFF;
    localparam logic [31:0] SAD_FLASH_BASE = 32'hFF00_0000;
    localparam int SAD_FLASH_BANK_BIT = 19;
    // ****************************************************************
    // Inbound PCI window onto DRAM.
    // ****************************************************************
    localparam logic [31:0] SAD_PCI_DRAM_BASE = 32'h8000_0000;
    // ****************************************************************
    // Indirect configuration ports and configuration select lines.
    // ****************************************************************
    localparam logic [15:0] SAD_CFG_ADDR_PORT = 16'h0CF8;
    localparam logic [15:0] SAD_CFG_DATA_PORT = 16'h0CFC;
    localparam int SAD_IDSEL_LO = 11;
    localparam int SAD_IDSEL_HI = 18;
    // ****************************************************************
    // Board control register ISA offsets.
    // ****************************************************************
    localparam logic [15:0] SAD_CLOCK_RAM_INDEX_LOW = 16'h0074;
    localparam logic [15:0] SAD_CLOCK_RAM_INDEX_HIGH = 16'h0075;
    localparam logic [15:0] SAD_CLOCK_RAM_DATA_PORT = 16'h0077;
    localparam logic [15:0] SAD_BOARD_KIND_INFO = 16'h0800;
    localparam logic [15:0] SAD_BOARD_BUILD_OPTIONS = 16'h0802;
    localparam logic [15:0] SAD_MEMORY_MODULE_INFO = 16'h0804;
    localparam logic [15:0] SAD_POWER_DOWN_CONTROL = 16'h0807;
    localparam logic [7:0] SAD_POWER_DOWN_RESET = 8'h00;
    localparam logic [7:0] SAD_CLOCK_RAM_INDEX_RESET = 8'h00;
    // ****************************************************************
    // Decoded targets.
    // ****************************************************************
    typedef enum logic [3:0] {
        SAD_T_NONE, SAD_T_DRAM, SAD_T_PCI_IO, SAD_T_PCI_CFG, SAD_T_PCI_RSV,
        SAD_T_PCI_IACK, SAD_T_PCI_MEM, SAD_T_FLASH0, SAD_T_FLASH1, SAD_T_BOARD
    } sad_target_e;
endpackage
`default_nettype wire

// File: hdl/sad_board_regs.sv
`default_nettype none
module sad_board_regs
    import sad_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Byte access.
    input wire logic acc,
    input wire logic wr,
    input wire logic [15:0] isa_addr,
    input wire logic [7:0] wdata,
    // Board inputs, already synchronised.
    input wire logic [7:0] kind_in,
    input wire logic [7:0] build_in,
    input wire logic [7:0] module_in,
    input wire logic [7:0] clock_ram_rdata,
    // Results.
    output logic hit_r,
    output logic [7:0] rdata_r,
    output logic [7:0] index_low_r,
    output logic [7:0] index_high_r,
    output logic [7:0] power_down_r,
    output logic clock_ram_wr_r,
    output logic clock_ram_rd_r,
    output logic [7:0] clock_ram_wdata_r
);
    logic hit;
    logic [7:0] rd;

    always_comb begin
        hit = 1'b1;
        rd = 8'h00;
        case (isa_addr)
            SAD_CLOCK_RAM_INDEX_LOW: hit = 1'b1;
            SAD_CLOCK_RAM_INDEX_HIGH: hit = 1'b1;
            SAD_CLOCK_RAM_DATA_PORT: rd = clock_ram_rdata;
            SAD_BOARD_KIND_INFO: rd = kind_in;
            SAD_BOARD_BUILD_OPTIONS: rd = build_in;
            SAD_MEMORY_MODULE_INFO: rd = module_in;
            SAD_POWER_DOWN_CONTROL: rd = power_down_r;
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hit_r <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            hit_r <= acc && hit;
            rdata_r <= (acc && !wr) ? rd : 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            index_low_r <= SAD_CLOCK_RAM_INDEX_RESET;
            index_high_r <= SAD_CLOCK_RAM_INDEX_RESET;
            power_down_r <= SAD_POWER_DOWN_RESET;
            clock_ram_wr_r <= 1'b0;
            clock_ram_rd_r <= 1'b0;
            clock_ram_wdata_r <= 8'h00;
        end else begin
            clock_ram_wr_r <= acc && wr && (isa_addr == SAD_CLOCK_RAM_DATA_PORT);
            clock_ram_rd_r <= acc && !wr && (isa_addr == SAD_CLOCK_RAM_DATA_PORT);
            if (acc && wr) begin
                clock_ram_wdata_r <= wdata;
                if (isa_addr == SAD_CLOCK_RAM_INDEX_LOW) index_low_r <= wdata;
                if (isa_addr == SAD_CLOCK_RAM_INDEX_HIGH) index_high_r <= wdata;
                if (isa_addr == SAD_POWER_DOWN_CONTROL) power_down_r <= wdata;
            end
        end
    end
endmodule // sad_board_regs
`default_nettype wire

// File: verification/sad_far_model.sv
`default_nettype none
module sad_far_model #(
    // Board strap values and interrupt vector; all are arbitrary test patterns.
    parameter logic [7:0] KIND = 8'h4C,
    parameter logic [7:0] BUILD = 8'h96,
    parameter logic [7:0] MODULE = 8'h3A,
    parameter logic [7:0] IACK = 8'h5E
) (
    // Clock.
    input wire logic clk,
    // Clock RAM strobes from the decoder.
    input wire logic [7:0] index_low_r,
    input wire logic [7:0] index_high_r,
    input wire logic clock_ram_wr_r,
    input wire logic [7:0] clock_ram_wdata_r,
    // Data returned to the decoder.
    output logic [7:0] kind_in,
    output logic [7:0] build_in,
    output logic [7:0] module_in,
    output logic [7:0] clock_ram_rdata,
    output logic [7:0] iack_vector
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem_r [0:2047];
    assign kind_in = KIND;
    assign build_in = BUILD;
    assign module_in = MODULE;
    assign iack_vector = IACK;
    // The clock RAM stores one byte at the index built from index_low_r and the low three bits of index_high_r.
    always_ff @(posedge clk) begin
        if (clock_ram_wr_r) begin
            mem_r[{index_high_r[2:0], index_low_r}] <= clock_ram_wdata_r;
        end
    end
    assign clock_ram_rdata = mem_r[{index_high_r[2:0], index_low_r}];
endmodule // sad_far_model
`default_nettype wire

// File: verification/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import sad_pkg::*;
    localparam logic [7:0] KIND = 8'h4C;
    localparam logic [7:0] BUILD = 8'h96;
    localparam logic [7:0] MODULE = 8'h3A;
    localparam logic [7:0] IACK = 8'h5E;
    logic clk, rst_n, cpu_req, cpu_wr, alt_map_pin, discontig_pin, pci_in_req, pci_in_io;
    logic [31:0] cpu_addr, pci_in_addr, pci_addr_r, dram_in_addr_r;
    logic [3:0] cpu_size;
    logic [7:0] cpu_wdata, kind_in, build_in, module_in, clock_ram_rdata, iack_vector;
    logic [7:0] idsel_r, rdata_r, index_low_r, index_high_r, power_down_r, clock_ram_wdata_r;
    logic dec_valid_r, pci_cfg_r, alt_map_r, clock_ram_wr_r, clock_ram_rd_r, dram_in_valid_r, pci_in_drop_r;
    sad_target_e dec_target_r;
    int miscompares, check_count, cycles;
    sad_decoder i_dut (.clk, .rst_n, .cpu_req, .cpu_wr, .cpu_addr, .cpu_size, .cpu_wdata, .alt_map_pin,
        .discontig_pin, .pci_in_req, .pci_in_io, .pci_in_addr, .kind_in, .build_in, .module_in,
        .clock_ram_rdata, .iack_vector, .dec_valid_r, .dec_target_r, .pci_addr_r, .pci_cfg_r, .idsel_r,
        .rdata_r, .alt_map_r, .index_low_r, .index_high_r, .power_down_r, .clock_ram_wr_r, .clock_ram_rd_r,
        .clock_ram_wdata_r, .dram_in_valid_r, .dram_in_addr_r, .pci_in_drop_r);
    sad_far_model #(.KIND(KIND), .BUILD(BUILD), .MODULE(MODULE), .IACK(IACK)) i_far (.clk, .index_low_r,
        .index_high_r, .clock_ram_wr_r, .clock_ram_wdata_r, .kind_in, .build_in, .module_in,
        .clock_ram_rdata, .iack_vector);
    // ****************************************************************
    // Shared helpers.
    // ****************************************************************
    task automatic fail(input string msg);
        miscompares++;
        $display("[ERR] %0t %s", $time, msg);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic cpu(input logic [31:0] a, input logic w, input logic [3:0] sz, input logic [7:0] d);
        @(posedge clk);
        cpu_req <= 1'b1;
        cpu_wr <= w;
        cpu_addr <= a;
        cpu_size <= sz;
        cpu_wdata <= d;
        @(posedge clk);
        cpu_req <= 1'b0;
        #1;
    endtask
    task automatic chk_dec(input sad_target_e t, input logic [31:0] a);
        check_count++;
        if (dec_valid_r !== 1'b1 || dec_target_r !== t || (t != SAD_T_DRAM && pci_addr_r !== a)) begin
            fail($sformatf("decode %s got %s at %h", t.name(), dec_target_r.name(), pci_addr_r));
        end
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            fail($sformatf("byte got %h want %h", got, exp));
        end
    endtask
    task automatic rd_byte(input logic [31:0] a, input logic [7:0] exp);
        cpu(a, 1'b0, 4'h1, 8'h00);
        @(posedge clk);
        #1;
        chk_byte(rdata_r, exp);
    endtask
    // ****************************************************************
    // Scenarios.
    // ****************************************************************
    task automatic t_reset();
        chk_byte({7'h00, dec_valid_r}, 8'h00);
        chk_byte({7'h00, alt_map_r}, 8'h00);
        chk_byte(power_down_r, SAD_POWER_DOWN_RESET);
        chk_byte(index_low_r, SAD_CLOCK_RAM_INDEX_RESET);
    endtask
    task automatic t_map();
        logic [31:0] ta [16] = '{32'h7FFF_FFFF, 32'h8000_0000, 32'h807F_FFFF, 32'h8080_0000, 32'h80FF_FFFF,
            32'h8100_0000, 32'hBF7F_FFFF, 32'hBF80_0000, 32'hBFFF_FFEF, 32'hC000_0000, 32'hFEFF_FFFF,
            32'hFF00_0000, 32'hFF08_0000, 32'hFFF7_FFFF, 32'hFFFF_FFFF, 32'h0000_0000};
        sad_target_e tt [16] = '{SAD_T_DRAM, SAD_T_PCI_IO, SAD_T_PCI_IO, SAD_T_PCI_CFG, SAD_T_PCI_CFG,
            SAD_T_PCI_IO, SAD_T_PCI_IO, SAD_T_PCI_RSV, SAD_T_PCI_RSV, SAD_T_PCI_MEM, SAD_T_PCI_MEM,
            SAD_T_FLASH0, SAD_T_FLASH1, SAD_T_FLASH0, SAD_T_FLASH1, SAD_T_DRAM};
        logic [31:0] exp;
        // Requests run back to back; each edge checks the request of the edge before.
        for (int i = 0; i <= 16; i++) begin
            @(posedge clk);
            cpu_req <= (i < 16);
            cpu_wr <= 1'b0;
            cpu_size <= 4'h4;
            cpu_addr <= ta[i % 16];
            #1;
            if (i > 0) begin
                exp = ta[i - 1] >= SAD_MEM_BASE ? ta[i - 1] - SAD_MEM_BASE : ta[i - 1] - SAD_IO_BASE;
                if (ta[i - 1] >= SAD_FLASH_BASE) exp = {12'h000, ta[i - 1][19:0]};
                chk_dec(tt[i - 1], exp);
            end
        end
    endtask
    task automatic t_idsel();
        for (int n = SAD_IDSEL_LO; n <= SAD_IDSEL_HI; n++) begin
            cpu(SAD_CFG_BASE | (32'h1 << n), 1'b0, 4'h4, 8'h00);
            chk_dec(SAD_T_PCI_CFG, 32'h0080_0000 | (32'h1 << n));
            chk_byte({idsel_r[7:1], pci_cfg_r}, {8'h01 << (n - SAD_IDSEL_LO)} | 8'h01);
            chk_byte({7'h00, idsel_r[0]}, {7'h00, n == SAD_IDSEL_LO});
        end
    endtask
    task automatic t_iack();
        cpu(SAD_IACK_BASE, 1'b0, 4'h1, 8'h00);
        chk_dec(SAD_T_PCI_IACK, 32'h3FFF_FFF0);
        @(posedge clk);
        #1;
        chk_byte(rdata_r, IACK);
        rd_byte(SAD_IACK_END, IACK);
        cpu(32'hBFFF_FFF8, 1'b1, 4'h1, 8'h00);
        chk_dec(SAD_T_PCI_RSV, 32'h3FFF_FFF8);
    endtask
    task automatic t_board();
        rd_byte(32'h8000_0800, KIND);
        rd_byte(32'h8000_0802, BUILD);
        rd_byte(32'h8000_0804, MODULE);
        cpu(32'h8000_0807, 1'b1, 4'h1, 8'h5A);
        rd_byte(32'h8000_0807, 8'h5A);
        chk_byte(power_down_r, 8'h5A);
        cpu(32'h8000_0800, 1'b0, 4'h4, 8'h00);
        chk_dec(SAD_T_PCI_IO, 32'h0000_0800);
        cpu(32'h8000_0300, 1'b0, 4'h1, 8'h00);
        chk_dec(SAD_T_PCI_IO, 32'h0000_0300);
        @(posedge clk);
        #1;
        chk_byte(rdata_r, 8'h5A);
    endtask
    task automatic t_clock_ram();
        cpu(32'h8000_0074, 1'b1, 4'h1, 8'h21);
        cpu(32'h8000_0075, 1'b1, 4'h1, 8'h03);
        cpu(32'h8000_0077, 1'b1, 4'h1, 8'hC3);
        cpu(32'h8000_0074, 1'b1, 4'h1, 8'h22);
        cpu(32'h8000_0077, 1'b1, 4'h1, 8'h3C);
        cpu(32'h8000_0074, 1'b1, 4'h1, 8'h21);
        chk_byte(index_high_r, 8'h03);
        chk_byte(index_low_r, 8'h21);
        rd_byte(32'h8000_0077, 8'hC3);
    endtask
    task automatic t_discontig();
        @(posedge clk);
        discontig_pin <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk_byte({7'h00, alt_map_r}, 8'h01);
        rd_byte(32'h8004_0000, KIND);
        rd_byte(32'h8004_0004, MODULE);
        @(posedge clk);
        discontig_pin <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk_byte({7'h00, alt_map_r}, 8'h00);
        cpu(32'h8000_0807, 1'b1, 4'h1, 8'h80);
        repeat (3) @(posedge clk);
        #1;
        chk_byte({7'h00, alt_map_r}, 8'h01);
        rd_byte(32'h8004_0002, BUILD);
        cpu(32'h8004_0007, 1'b1, 4'h1, 8'h00);
        repeat (3) @(posedge clk);
        #1;
        chk_byte({7'h00, alt_map_r}, 8'h00);
    endtask
    task automatic t_cf8();
        for (int i = 0; i < 4; i++) begin
            cpu(32'h8000_0CF8 + i, 1'b1, 4'h1, i == 1 ? 8'h08 : (i == 3 ? 8'h80 : 8'h00));
        end
        cpu(32'h8000_0CFC, 1'b0, 4'h4, 8'h00);
        check_count++;
        if (dec_valid_r !== 1'b1 || dec_target_r !== SAD_T_PCI_CFG || pci_cfg_r !== 1'b1) begin
            fail("indirect configuration cycle not produced");
        end
    endtask
    task automatic t_inbound();
        logic [31:0] ia [5] = '{32'h8000_0000, 32'hFFFF_FFFF, 32'h7FFF_FFFF, 32'h00FF_FFFF, 32'h8000_0000};
        logic [4:0] io = 5'b10000;
        logic [4:0] hit = 5'b00011;
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            pci_in_req <= 1'b1;
            pci_in_io <= io[i];
            pci_in_addr <= ia[i];
            @(posedge clk);
            pci_in_req <= 1'b0;
            #1;
            chk_byte({6'h00, dram_in_valid_r, pci_in_drop_r}, {6'h00, hit[i], !hit[i]});
            if (hit[i]) chk_byte(dram_in_addr_r[31:24], ia[i][31:24] - 8'h80);
        end
    endtask
    // ****************************************************************
    // Clock, timeout and main sequence.
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail("timeout");
            final_report();
        end
    end
    initial begin
        {rst_n, cpu_req, cpu_wr, alt_map_pin, discontig_pin, pci_in_req, pci_in_io} = '0;
        {cpu_addr, pci_in_addr, cpu_size, cpu_wdata} = '0;
        miscompares = 0;
        check_count = 0;
        cycles = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        t_reset();
        t_map();
        t_idsel();
        t_iack();
        t_board();
        t_clock_ram();
        t_discontig();
        t_cf8();
        t_inbound();
        final_report();
    end
endmodule // tb
`default_nettype wire
